// ==== sysctl_regs.sv ====
/*
 * core identification, translation result, reset management and el1
 * system control register bank, reached over apb.
 * assumes configuration inputs are stable and synchronous to clk_sys_in.
 */
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - affinity register 64 bits, read-only
// - bits 39:32 return level-three cluster input
// - bits 23:16 return level-two cluster input
// - bit 30 reports multiprocessor membership
// - bit 24 reads as one
// - bits 15:11 zero, 10:8 core index
// - bits 7:0 always zero
// - both halves mirrored to debug affinity outputs
// - result bit 0 marks translation abort
// - result bit 10 reads zero on success
// - revision-fix word 32 bits read-only
// - reset request clears on reset, write requests
// - reset request only drives external request
// - vector base read-only, low two, high zero
// - vector holds 64-bit start fetch address
// - el1 control loads documented reset pattern
// - bit 44 copied to bypass-safe on entry
// - bits 31,30,27,13 enable pointer-auth uses
// - bit 25 selects el1 data endianness
// - bit 21 adds error sync events
// - bit 7 reads zero, writes ignored
// - bit 6 relaxes ordered alignment faults
module sysctl_regs
  import sysctl_pkg::*;
#(
  parameter int CORE_IDX_W = 3,
  parameter logic [31:0] REVFIX_VALUE = 32'h0000_0000,
  parameter logic [63:0] VECTOR_VALUE = 64'h0000_0000_0000_0000
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic warm_resetn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] cluster_level3_cfg_in,
  input wire logic [7:0] cluster_level2_cfg_in,
  input wire logic [CORE_IDX_W-1:0] core_index_in,
  input wire xlate_s xlate_in,
  input wire logic exc_to_el1_in,
  input wire logic exception_return_instr_in,
  output logic [31:0] debug_affinity_low_out,
  output logic [31:0] debug_affinity_high_out,
  output logic warm_reset_request_out,
  output logic store_bypass_safe_flag_out,
  output logic err_sync_event_out,
  output sct_ctrl_s sct_ctrl_out
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] half(input logic [63:0] v, input logic hi);
    half = hi ? v[63:32] : v[31:0];
  endfunction

  function automatic logic [63:0] merge(input logic [63:0] old, input logic hi,
                                        input logic [31:0] wd);
    logic [63:0] nv;
    nv = old;
    if (hi) begin
      nv[63:32] = wd;
    end else begin
      nv[31:0] = wd;
    end
    merge = (nv & SCT_WMASK) | SCT_RES1;
  endfunction

  apb_state_e state_r;
  logic [63:0] affinity;
  logic [63:0] par_r;
  logic [63:0] sct_r;
  logic rr_r;
  logic bypass_r;
  logic esync_r;
  logic [1:0] ev_r;
  logic [31:0] rdata_r;
  logic [31:0] mem_rdata;
  logic [1:0] mem_sel;
  logic mem_hit;
  logic mem_hit_r;
  logic wr_take;
  logic rd_take;
  logic known;

  // ************************************************************
  // affinity word
  // ************************************************************
  always_comb begin
    affinity = 64'h0000_0000_0000_0000;
    affinity[AFF_TOP_LSB +: 8] = cluster_level3_cfg_in;
    affinity[AFF_SECOND_LSB +: 8] = cluster_level2_cfg_in;
    affinity[AFF_RES1_BIT] = 1'b1;
    affinity[AFF_UNI_BIT] = AFF_UNI_MULTI;
    affinity[AFF_MT_BIT] = AFF_MT_VALUE;
    affinity[AFF_CORE_LSB +: CORE_IDX_W] = core_index_in;
    // thread field stays zero
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      debug_affinity_low_out <= 32'h0000_0000;
      debug_affinity_high_out <= 32'h0000_0000;
    end else if (ce_in) begin
      debug_affinity_low_out <= affinity[31:0];
      debug_affinity_high_out <= affinity[63:32];
    end
  end

  // ************************************************************
  // apb handshake
  // ************************************************************
  assign wr_take = psel && penable && pwrite && pready && ce_in;
  assign rd_take = psel && !penable && !pwrite && ce_in;
  assign pready = (state_r == APB_ACCESS);
  assign mem_hit = (paddr == ADDR_REVFIX) || (paddr == ADDR_VEC_LO) ||
                   (paddr == ADDR_VEC_HI);

  always_comb begin
    case (paddr)
      ADDR_VEC_LO: mem_sel = 2'h1;
      ADDR_VEC_HI: mem_sel = 2'h2;
      default: mem_sel = 2'h0;
    endcase
  end

  always_comb begin
    case (paddr)
      ADDR_AFF_LO, ADDR_AFF_HI, ADDR_PAR_LO, ADDR_PAR_HI, ADDR_REVFIX,
      ADDR_RSTMGT, ADDR_VEC_LO, ADDR_VEC_HI, ADDR_SCT_LO, ADDR_SCT_HI,
      ADDR_EVENT, ADDR_STATUS: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= APB_IDLE;
    end else if (ce_in) begin
      case (state_r)
        APB_IDLE: state_r <= (psel && !penable) ? APB_SETUP : APB_IDLE;
        APB_SETUP: state_r <= APB_ACCESS;
        APB_ACCESS: state_r <= (psel && !penable) ? APB_SETUP : APB_IDLE;
        default: state_r <= APB_IDLE;
      endcase
    end
  end

  assign pslverr = pready && !known;

  // ************************************************************
  // read data
  // ************************************************************
  sysctl_word_mem #(
    .REVFIX_VALUE(REVFIX_VALUE),
    .VECTOR_VALUE(VECTOR_VALUE)
  ) u_mem (
    .clk_sys_in(clk_sys_in),
    .resetn_in(resetn_in),
    .ce_in(ce_in),
    .sel_in(mem_sel),
    .rdata_out(mem_rdata)
  );

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_r <= 32'h0000_0000;
      mem_hit_r <= 1'b0;
    end else if (rd_take) begin
      mem_hit_r <= mem_hit;
      case (paddr)
        ADDR_AFF_LO: rdata_r <= half(affinity, 1'b0);
        ADDR_AFF_HI: rdata_r <= half(affinity, 1'b1);
        ADDR_PAR_LO: rdata_r <= half(par_r, 1'b0);
        ADDR_PAR_HI: rdata_r <= half(par_r, 1'b1);
        ADDR_RSTMGT: rdata_r <= {30'h0000_0000, rr_r, 1'b1};
        ADDR_SCT_LO: rdata_r <= half(sct_r, 1'b0);
        ADDR_SCT_HI: rdata_r <= half(sct_r, 1'b1);
        ADDR_EVENT: rdata_r <= {30'h0000_0000, ev_r};
        ADDR_STATUS: rdata_r <= {29'h0000_0000, esync_r, bypass_r, rr_r};
        default: rdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = pready ? (mem_hit_r ? mem_rdata : rdata_r) : 32'h0000_0000;

  // ************************************************************
  // translation result
  // ************************************************************
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      par_r <= 64'h0000_0000_0000_0000;
    end else if (ce_in) begin
      if (xlate_in.valid) begin
        par_r <= 64'h0000_0000_0000_0000;
        par_r[PAR_FAULT_BIT] <= xlate_in.fault;
        if (!xlate_in.fault) begin
          par_r[63:12] <= xlate_in.addr;
        end
      end else if (wr_take && paddr == ADDR_PAR_LO) begin
        par_r[31:0] <= pwdata & ~(32'h0000_0001 << PAR_IMPDEF_BIT);
      end else if (wr_take && paddr == ADDR_PAR_HI) begin
        par_r[63:32] <= pwdata;
      end
    end
  end

  // ************************************************************
  // reset management
  // ************************************************************
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rr_r <= 1'b0;
    end else if (!warm_resetn_in) begin
      rr_r <= 1'b0;
    end else if (ce_in && wr_take && paddr == ADDR_RSTMGT) begin
      rr_r <= pwdata[RR_BIT];
    end
  end

  assign warm_reset_request_out = rr_r;

  // ************************************************************
  // el1 system control
  // ************************************************************
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sct_r <= SCT_RESET;
    end else if (!warm_resetn_in) begin
      sct_r <= SCT_RESET;
    end else if (wr_take && paddr == ADDR_SCT_LO) begin
      sct_r <= merge(sct_r, 1'b0, pwdata);
    end else if (wr_take && paddr == ADDR_SCT_HI) begin
      sct_r <= merge(sct_r, 1'b1, pwdata);
    end
  end

  always_comb begin
    sct_ctrl_out.pauth_instr_key_a = sct_r[SCT_PAUTH_INSTR_KEY_A];
    sct_ctrl_out.pauth_instr_key_b = sct_r[SCT_PAUTH_INSTR_KEY_B];
    sct_ctrl_out.pauth_data_key_a = sct_r[SCT_PAUTH_DATA_KEY_A];
    sct_ctrl_out.pauth_data_key_b = sct_r[SCT_PAUTH_DATA_KEY_B];
    sct_ctrl_out.exception_endianness = sct_r[SCT_EE];
    sct_ctrl_out.implicit_err_sync_enable = sct_r[SCT_IMPLICIT_ERR_SYNC_ENABLE];
    sct_ctrl_out.ordered_align_relax = sct_r[SCT_NAA];
  end

  // ************************************************************
  // exception entry and return
  // ************************************************************
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bypass_r <= 1'b0;
      esync_r <= 1'b0;
      ev_r <= 2'b00;
    end else if (ce_in) begin
      if (exc_to_el1_in) begin
        bypass_r <= sct_r[SCT_DEFAULT_BYPASS_SAFE_ON_TRAP];
      end
      esync_r <= sct_r[SCT_IMPLICIT_ERR_SYNC_ENABLE] && (exc_to_el1_in || exception_return_instr_in);
      if (wr_take && paddr == ADDR_EVENT) begin
        ev_r <= (ev_r & ~pwdata[1:0]) | {exception_return_instr_in, exc_to_el1_in};
      end else begin
        ev_r <= ev_r | {exception_return_instr_in, exc_to_el1_in};
      end
    end
  end

  assign store_bypass_safe_flag_out = bypass_r;
  assign err_sync_event_out = esync_r;

endmodule
`default_nettype wire

// ==== sysctl_pkg.sv ====
/*
 * constants, register map and field layouts for the core identification,
 * reset management and system control register bank.
 * assumes a 32-bit apb slave with word-aligned registers.
 */
package sysctl_pkg;

  // ************************************************************
  // register map (byte addresses, 32-bit words)
  // ************************************************************
  localparam logic [7:0] ADDR_AFF_LO = 8'h00;
  localparam logic [7:0] ADDR_AFF_HI = 8'h04;
  localparam logic [7:0] ADDR_PAR_LO = 8'h08;
  localparam logic [7:0] ADDR_PAR_HI = 8'h0C;
  localparam logic [7:0] ADDR_REVFIX = 8'h10;
  localparam logic [7:0] ADDR_RSTMGT = 8'h14;
  localparam logic [7:0] ADDR_VEC_LO = 8'h18;
  localparam logic [7:0] ADDR_VEC_HI = 8'h1C;
  localparam logic [7:0] ADDR_SCT_LO = 8'h20;
  localparam logic [7:0] ADDR_SCT_HI = 8'h24;
  localparam logic [7:0] ADDR_EVENT = 8'h28;
  localparam logic [7:0] ADDR_STATUS = 8'h2C;
  localparam int NUM_WORDS = 12;

  // ************************************************************
  // affinity fields
  // ************************************************************
  localparam int AFF_TOP_LSB = 32;
  localparam int AFF_SECOND_LSB = 16;
  localparam int AFF_CORE_LSB = 8;
  localparam int AFF_RES1_BIT = 31;
  localparam int AFF_UNI_BIT = 30;
  localparam int AFF_MT_BIT = 24;
  localparam logic AFF_MT_VALUE = 1'b1;
  localparam logic AFF_UNI_MULTI = 1'b0;

  // ************************************************************
  // translation result, reset management, reset vector
  // ************************************************************
  localparam int PAR_FAULT_BIT = 0;
  localparam int PAR_IMPDEF_BIT = 10;
  localparam int RR_BIT = 1;
  localparam int RMR_RES1_BIT = 0;
  localparam int PA_BITS = 40;
  localparam logic [63:0] VEC_MASK = 64'h0000_00FF_FFFF_FFFC;

  // ************************************************************
  // el1 system control fields
  // ************************************************************
  localparam logic [63:0] SCT_RESET = 64'h0000_0000_30D5_0838;
  localparam logic [63:0] SCT_WMASK = 64'h0000_1000_CFFF_FF7F;
  localparam logic [63:0] SCT_RES1 = 64'h0000_0000_3000_0000;
  localparam int SCT_DEFAULT_BYPASS_SAFE_ON_TRAP = 44;
  localparam int SCT_PAUTH_INSTR_KEY_A = 31;
  localparam int SCT_PAUTH_INSTR_KEY_B = 30;
  localparam int SCT_PAUTH_DATA_KEY_A = 27;
  localparam int SCT_EE = 25;
  localparam int SCT_IMPLICIT_ERR_SYNC_ENABLE = 21;
  localparam int SCT_PAUTH_DATA_KEY_B = 13;
  localparam int SCT_ITD = 7;
  localparam int SCT_NAA = 6;

  // event register bits
  localparam int EV_TAKE_EL1 = 0;
  localparam int EV_EXCEPTION_RETURN_INSTR_EL1 = 1;

  // apb access state
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_SETUP = 2'b01,
    APB_ACCESS = 2'b11
  } apb_state_e;

  typedef struct packed {
    logic pauth_instr_key_a;
    logic pauth_instr_key_b;
    logic pauth_data_key_a;
    logic pauth_data_key_b;
    logic exception_endianness;
    logic implicit_err_sync_enable;
    logic ordered_align_relax;
  } sct_ctrl_s;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [51:0] addr;
  } xlate_s;

endpackage

// ==== sysctl_word_mem.sv ====
/*
 * small word store for the revision-fix word and reset vector: loaded
 * from parameters, read through a registered output.
 * assumes clock enable gates every update.
 */
`timescale 1ns/1ps
`default_nettype none
module sysctl_word_mem #(
  parameter logic [31:0] REVFIX_VALUE = 32'h0000_0000,
  parameter logic [63:0] VECTOR_VALUE = 64'h0000_0000_0000_0000
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic [1:0] sel_in,
  output logic [31:0] rdata_out
);
  import sysctl_pkg::*;

  logic [31:0] words [0:2];

  // ************************************************************
  // constant contents
  // ************************************************************
  assign words[0] = REVFIX_VALUE;
  assign words[1] = VECTOR_VALUE[31:0] & VEC_MASK[31:0];
  assign words[2] = VECTOR_VALUE[63:32] & VEC_MASK[63:32];

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (ce_in) begin
      rdata_out <= (sel_in <= 2'h2) ? words[sel_in] : 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ==== sysctl_regs_monitor.sv ====
/* checker for the register bank ports
   assumes a bind onto sysctl_regs from the testbench */
`timescale 1ns/1ps
`default_nettype none
module sysctl_regs_monitor
  import sysctl_pkg::*;
#(
  parameter int CORE_IDX_W = 3
) (
  input wire logic clk_sys_in,
  input wire logic resetn_in,
  input wire logic ce_in,
  input wire logic warm_resetn_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] cluster_level2_cfg_in,
  input wire logic [7:0] cluster_level3_cfg_in,
  input wire logic [CORE_IDX_W-1:0] core_index_in,
  input wire logic exc_to_el1_in,
  input wire logic exception_return_instr_in,
  input wire logic [31:0] debug_affinity_low_out,
  input wire logic [31:0] debug_affinity_high_out,
  input wire logic warm_reset_request_out,
  input wire logic store_bypass_safe_flag_out,
  input wire logic err_sync_event_out,
  input wire sct_ctrl_s sct_ctrl_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  // ************************
  // assertions
  // ************************
  a_debug_low_mirror: assert property ($past(ce_in) && $past(resetn_in) |->
    debug_affinity_low_out == {1'b1, AFF_UNI_MULTI, 5'h0, AFF_MT_VALUE,
    $past(cluster_level2_cfg_in), 8'($past(core_index_in)), 8'h00}) else $error("debug low");
  a_debug_high_mirror: assert property ($past(ce_in) && $past(resetn_in) |->
    debug_affinity_high_out == {24'h0, $past(cluster_level3_cfg_in)}) else $error("debug high");
  a_one_wait: assert property (psel && !penable && ce_in |-> ##2 pready) else $error("no ready");
  a_ready_cause: assert property (pready |-> psel && penable) else $error("stray ready");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_idle_data: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
  a_request_write: assert property (psel && penable && pwrite && pready && ce_in && warm_resetn_in
    && paddr == ADDR_RSTMGT |=> warm_reset_request_out == $past(pwdata[RR_BIT]))
    else $error("request write");
  a_warm_clear: assert property (!warm_resetn_in && ce_in |=>
    !warm_reset_request_out && sct_ctrl_out == 7'h0) else $error("warm reset");
  a_esync_cause: assert property (err_sync_event_out |->
    $past(exc_to_el1_in || exception_return_instr_in)
    && $past(sct_ctrl_out.implicit_err_sync_enable)) else $error("esync");
  a_bypass_hold: assert property ($past(resetn_in) && $past(warm_resetn_in)
    && !$past(exc_to_el1_in) |-> $stable(store_bypass_safe_flag_out)) else $error("bypass");
  c_request: cover property (warm_reset_request_out);
  c_esync: cover property (err_sync_event_out);
  c_error: cover property (pslverr);
endmodule
`default_nettype wire

// ==== testbench.sv ====
/* self-checking bench for the register bank
   assumes sysctl_pkg and the design files compiled before it */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sysctl_pkg::*;
  logic clk_sys_in = 0, resetn_in = 0, ce_in = 1, warm_resetn_in = 1;
  logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 0, cluster_level3_cfg_in = 0, cluster_level2_cfg_in = 0;
  logic [31:0] pwdata = 0, prdata, debug_affinity_low_out, debug_affinity_high_out;
  logic [2:0] core_index_in = 0;
  xlate_s xlate_in = '0;
  logic exc_to_el1_in = 0, exception_return_instr_in = 0;
  logic warm_reset_request_out, store_bypass_safe_flag_out, err_sync_event_out;
  sct_ctrl_s sct_ctrl_out;
  int n_mismatch = 0, total_checks = 0, i, j;
  logic [31:0] seed = 32'h6CC6, rd;
  logic [63:0] v, aff, sct_m;
  logic er;
  logic [7:0] ro_a [5] = '{ADDR_AFF_LO, ADDR_AFF_HI, ADDR_REVFIX, ADDR_VEC_LO, ADDR_VEC_HI};
  sysctl_regs i_sysctl_regs (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(ce_in),
    .warm_resetn_in(warm_resetn_in), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cluster_level3_cfg_in(cluster_level3_cfg_in), .cluster_level2_cfg_in(cluster_level2_cfg_in),
    .core_index_in(core_index_in), .xlate_in(xlate_in), .exc_to_el1_in(exc_to_el1_in),
    .exception_return_instr_in(exception_return_instr_in),
    .debug_affinity_low_out(debug_affinity_low_out),
    .debug_affinity_high_out(debug_affinity_high_out),
    .warm_reset_request_out(warm_reset_request_out),
    .store_bypass_safe_flag_out(store_bypass_safe_flag_out),
    .err_sync_event_out(err_sync_event_out), .sct_ctrl_out(sct_ctrl_out));
  always #5 clk_sys_in = ~clk_sys_in;
  // ************************
  // helpers
  // ************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1;
    do @(posedge clk_sys_in); while (pready !== 1'b1 && ++n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd64(input logic [7:0] a);
    apb(0, a, 0);
    v[31:0] = rd;
    apb(0, a + 8'h04, 0);
    v[63:32] = rd;
  endtask
  task automatic pulse_exc(input logic ret);
    @(posedge clk_sys_in);
    exc_to_el1_in <= !ret;
    exception_return_instr_in <= ret;
    @(posedge clk_sys_in);
    exc_to_el1_in <= 0;
    exception_return_instr_in <= 0;
    #1;
  endtask
  task automatic xl(input logic f);
    @(posedge clk_sys_in);
    xlate_in <= '{1'b1, f, 52'hF_FFFF_FFFF_FFFF};
    @(posedge clk_sys_in);
    xlate_in <= '0;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end
  // ************************
  // tests
  // ************************
  initial begin
    repeat (3) @(posedge clk_sys_in);
    resetn_in <= 1;
    apb(0, ADDR_RSTMGT, 0);
    chk("reset mgmt", 64'h1, {32'h0, rd});
    rd64(ADDR_SCT_LO);
    chk("control reset", 64'h0000_0000_30D5_0838, v);
    chk("ctrl out", 7'h0, sct_ctrl_out);
    for (i = 0; i < 3; i++) begin
      @(posedge clk_sys_in);
      cluster_level3_cfg_in <= 8'(rnd());
      cluster_level2_cfg_in <= 8'(rnd());
      core_index_in <= 3'(rnd());
      for (j = 0; j < 5; j++) apb(1, ro_a[j], rnd());
      aff = {24'h0, cluster_level3_cfg_in, 8'h81, cluster_level2_cfg_in, 5'h0, core_index_in, 8'h0};
      rd64(ADDR_AFF_LO);
      chk("affinity", aff, v);
      chk("debug affinity", aff, {debug_affinity_high_out, debug_affinity_low_out});
      apb(0, ADDR_REVFIX, 0);
      chk("revision fixes", 64'h0, {32'h0, rd});
      rd64(ADDR_VEC_LO);
      chk("vector", 64'h0, v);
    end
    $display("test read-only done");
    for (i = 0; i < 5; i++) begin
      v = (i == 4) ? 64'h0000_1000_0020_0000 : {rnd(), rnd()};
      sct_m = (v & SCT_WMASK) | SCT_RES1;
      apb(1, ADDR_SCT_LO, v[31:0]);
      apb(1, ADDR_SCT_HI, v[63:32]);
      rd64(ADDR_SCT_LO);
      chk("control", sct_m, v);
      chk("ctrl out", {sct_m[31:30], sct_m[27], sct_m[13], sct_m[25], sct_m[21], sct_m[6]},
        sct_ctrl_out);
    end
    $display("test control done");
    pulse_exc(0);
    chk("bypass", 1, store_bypass_safe_flag_out);
    chk("esync", 1, err_sync_event_out);
    pulse_exc(1);
    chk("esync ret", 1, err_sync_event_out);
    apb(0, ADDR_EVENT, 0);
    chk("events", 64'h3, {32'h0, rd});
    apb(1, ADDR_SCT_HI, 0);
    pulse_exc(0);
    chk("bypass clear", 0, store_bypass_safe_flag_out);
    $display("test exception done");
    apb(1, ADDR_RSTMGT, 32'h2);
    #1;
    chk("request", 1, warm_reset_request_out);
    apb(0, ADDR_RSTMGT, 0);
    chk("reset mgmt", 64'h3, {32'h0, rd});
    @(posedge clk_sys_in);
    warm_resetn_in <= 0;
    @(posedge clk_sys_in);
    warm_resetn_in <= 1;
    rd64(ADDR_SCT_LO);
    chk("request warm", 0, warm_reset_request_out);
    chk("control warm", 64'h0000_0000_30D5_0838, v);
    $display("test reset request done");
    xl(0);
    apb(0, ADDR_PAR_LO, 0);
    chk("xlate ok", 0, {rd[10], rd[0]});
    ce_in <= 0;
    xl(1);
    ce_in <= 1;
    apb(0, ADDR_PAR_LO, 0);
    chk("xlate frozen", 0, rd[0]);
    xl(1);
    rd64(ADDR_PAR_LO);
    chk("xlate abort", 64'h1, v);
    apb(0, 8'h30, 0);
    chk("unmapped", 33'h1_0000_0000, {er, rd});
    $display("test xlate done");
    finish_test();
  end
endmodule
bind sysctl_regs sysctl_regs_monitor #(.CORE_IDX_W(CORE_IDX_W)) i_sysctl_regs_monitor (
  .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .ce_in(ce_in),
  .warm_resetn_in(warm_resetn_in), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cluster_level2_cfg_in(cluster_level2_cfg_in), .cluster_level3_cfg_in(cluster_level3_cfg_in),
  .core_index_in(core_index_in), .exc_to_el1_in(exc_to_el1_in),
  .exception_return_instr_in(exception_return_instr_in),
  .debug_affinity_low_out(debug_affinity_low_out),
  .debug_affinity_high_out(debug_affinity_high_out),
  .warm_reset_request_out(warm_reset_request_out),
  .store_bypass_safe_flag_out(store_bypass_safe_flag_out),
  .err_sync_event_out(err_sync_event_out), .sct_ctrl_out(sct_ctrl_out));
`default_nettype wire
